// >>> icd_dec_if.sv
// Bundle between the core decoder and its primary and operand helpers
`timescale 1ns/10ps
interface icd_dec_if;
   logic [31:0]           word;     // Captured instruction word
   icd_pkg::icd_pkind_type pKind;   // Primary opcode verdict
   icd_pkg::icd_unit_type  pUnit;   // Unit for primary-only forms
   logic                  pMem;     // Primary form touches memory
   icd_pkg::icd_size_type  pSize;   // Its operand size
   logic                  pFp;      // Its target is a float register
   logic [4:0]            rDst;     // Operand register indices
   logic [4:0]            rSrcA;
   logic [4:0]            rSrcB;

   modport prim (input word, output pKind, output pUnit, output pMem, output pSize, output pFp);
   modport oper (input word, output rDst, output rSrcA, output rSrcB);
   modport core (output word, input pKind, input pUnit, input pMem, input pSize, input pFp,
                 input rDst, input rSrcA, input rSrcB);
endinterface

// >>> icd_decoder_properties.sv
// Concurrent checks on the instruction class decoder top ports
`timescale 1ns/10ps
module icd_decoder_properties (
   input logic                   sys_clk,
   input logic                   rst,
   input logic                   fetchValid,
   input logic [31:0]            fetchAddr,
   input logic [31:0]            fetchWord,
   input logic                   issueValid,
   input logic [31:0]            issuePc,
   input logic [31:0]            issueWord,
   input icd_pkg::icd_class_type issueClass,
   input icd_pkg::icd_unit_type  issueUnit,
   input logic                   progExc,
   input logic [31:0]            excVector
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   issue_lat_a : assert property (fetchValid |-> ##2 issueValid)
      else $error("Word not issued two cycles after capture");
   word_pass_a : assert property (fetchValid |-> ##2 issueWord == $past(fetchWord, 2))
      else $error("Issued word differs from fetched word");
   pc_align_a : assert property (fetchValid |-> ##2 issuePc == ($past(fetchAddr, 2) & 32'hFFFF_FFFC))
      else $error("Issue address not the aligned fetch address");
   zero_ill_a : assert property ((fetchValid && fetchWord == 32'h0000_0000)
      |-> ##2 (issueClass == icd_pkg::CLS_ILLEGAL && progExc)) else $error("Zero word not trapped");
   rsv_cls_a : assert property ((fetchValid && fetchWord[31:26] == 6'h00 && fetchWord[25:0] != 26'h0)
      |-> ##2 (issueClass == icd_pkg::CLS_RESERVED && progExc)) else $error("Opcode zero word not reserved");
   wide_ill_a : assert property ((fetchValid && fetchWord[31:26] inside {6'h02, 6'h1E, 6'h3A, 6'h3E})
      |-> ##2 (issueClass == icd_pkg::CLS_ILLEGAL && progExc)) else $error("Wide-only opcode accepted");
   exc_vec_a : assert property (issueValid |-> excVector == (progExc ? 32'h0000_0700 : 32'h0000_0000))
      else $error("Wrong exception vector");
   trap_unit_a : assert property (progExc |-> issueValid && issueUnit == icd_pkg::UNIT_NONE)
      else $error("Trapped word still routed to a unit");
   ill_trap_a : assert property ((issueValid && issueClass == icd_pkg::CLS_ILLEGAL) |-> progExc)
      else $error("Illegal word issued without trap");
endmodule // icd_decoder_properties
bind icd_instruction_class_decoder icd_decoder_properties CHK (.sys_clk, .rst, .fetchValid, .fetchAddr,
   .fetchWord, .issueValid, .issuePc, .issueWord, .issueClass, .issueUnit, .progExc, .excVector);

// >>> icd_fetch_model.sv
// Fetch path model that offers words to the decoder
`timescale 1ns/10ps
module icd_fetch_model (
   input  logic        sys_clk,
   output logic        fetchValid,
   output logic [31:0] fetchAddr,
   output logic [31:0] fetchWord
);
   initial begin
      fetchValid = 1'b0;
      fetchAddr  = 32'h0000_0000;
      fetchWord  = 32'hFFFF_FFFF;
   end
   // One word per cycle, launched just after the edge
   task automatic offer(input logic [31:0] w, input logic [31:0] a);
      @(posedge sys_clk);
      #1;
      fetchValid = 1'b1;
      fetchWord  = w;
      fetchAddr  = a;
   endtask
   // Idle: buses flip so stale words stand out
   task automatic idle();
      @(posedge sys_clk);
      #1;
      fetchValid = 1'b0;
      fetchWord  = ~fetchWord;
      fetchAddr  = ~fetchAddr;
   endtask
endmodule // icd_fetch_model

// >>> icd_instruction_class_decoder.sv
// Top of the instruction class decoder: class, exception and issue routing
// Function
// [RQ1] Instructions are aligned four-byte words
// [RQ2] 32 integer registers; byte, half, word moves
// [RQ3] 32 float registers; word, double moves
// [RQ4] Integer ops on words; float single, double
// [RQ5] Arithmetic never touches memory directly
// [RQ6] Class from primary and extended opcode
// [RQ7] Unmatched encodings are illegal
// [RQ8] Listed unassigned primary opcodes are illegal
// [RQ9] Wide-core-only primary opcodes are illegal
// [RQ10] Unassigned extended opcodes in groups illegal
// [RQ11] All-zero word is always illegal
// [RQ12] Opcode zero with other bits: reserved
// [RQ13] Illegal words trap to program vector
// [RQ14] All narrow-core operations run in hardware; square roots and translation flush-all trap instead
// [RQ15] Square roots, translation flush-all trap
// [RQ16] Bad reserved bits never raise privilege
// [RQ17] Unimplemented reserved words trap
// [RQ18] Opcode from top six bits, before issue
`timescale 1ns/10ps
`include "icd_regs.svh"
module icd_instruction_class_decoder (
   input  wire logic                  sys_clk,     // 50 MHz core clock
   input  wire logic                  rst,         // Asynchronous, active high
   input  wire logic                  fetchValid,  // Fetch path offers a word
   input  wire logic [31:0]           fetchAddr,   // Its fetch address
   input  wire logic [31:0]           fetchWord,   // The word itself
   input  wire logic                  userMode,    // Running at user level
   output logic                       issueValid,  // Decoded word ready for issue
   output logic [31:0]                issuePc,     // Word-aligned address
   output logic [31:0]                issueWord,   // Word as fetched
   output icd_pkg::icd_class_type     issueClass,  // Architectural class
   output icd_pkg::icd_unit_type      issueUnit,   // Receiving unit, none on trap
   output logic                       memAccess,   // Load or store
   output icd_pkg::icd_size_type      memSize,     // Its operand size
   output logic                       floatReg,    // Data register is a float register
   output logic [4:0]                 regDst,      // Operand register indices
   output logic [4:0]                 regSrcA,
   output logic [4:0]                 regSrcB,
   output logic                       progExc,     // Program exception, illegal or privileged instruction
   output logic                       privExc,     // Privileged-instruction program exception
   output logic [31:0]                excVector    // Vector offset while an exception stands
);

   // ----------------------------------------------------------------------------
   // Extended opcode tables
   // ----------------------------------------------------------------------------
   // Integer group, ten-bit forms assigned to the narrow core
   function automatic logic extIntLegal(input logic [9:0] xo);
      unique case (xo)
         10'h000, 10'h004, 10'h013, 10'h014, 10'h017, 10'h018, 10'h01A, 10'h01C,
         10'h020, 10'h036, 10'h037, 10'h03C, 10'h053, 10'h056, 10'h057, 10'h077,
         10'h07C, 10'h090, 10'h092, 10'h096, 10'h097, 10'h0B7, 10'h0D2, 10'h0D7,
         10'h0F2, 10'h0F6, 10'h0F7, 10'h116, 10'h117, 10'h11C, 10'h132, 10'h136,
         10'h137, 10'h13C, 10'h153, 10'h157, 10'h172, 10'h173, 10'h177, 10'h197,
         10'h19C, 10'h1B6, 10'h1B7, 10'h1BC, 10'h1D3, 10'h1D6, 10'h1DC, 10'h200,
         10'h215, 10'h216, 10'h217, 10'h218, 10'h236, 10'h237, 10'h253, 10'h255,
         10'h256, 10'h257, 10'h277, 10'h293, 10'h295, 10'h296, 10'h297, 10'h2B7,
         10'h2D5, 10'h2D7, 10'h2F7, 10'h316, 10'h318, 10'h338, 10'h356, 10'h396,
         10'h39A, 10'h3BA, 10'h3D6, 10'h3D7, 10'h3F6: extIntLegal = 1'b1;
         default:                                    extIntLegal = 1'b0;
      endcase
   endfunction

   // Integer group, nine-bit forms with an overflow-enable bit above them
   function automatic logic extXoLegal(input logic [8:0] xo);
      unique case (xo)
         9'h008, 9'h00A, 9'h00B, 9'h028, 9'h04B, 9'h068, 9'h088, 9'h08A,
         9'h0C8, 9'h0CA, 9'h0E8, 9'h0EA, 9'h0EB, 9'h10A, 9'h1CB, 9'h1EB: extXoLegal = 1'b1;
         default:                                                        extXoLegal = 1'b0;
      endcase
   endfunction

   // Condition register and branch-to-register group
   function automatic logic extCrLegal(input logic [9:0] xo);
      unique case (xo)
         10'h000, 10'h010, 10'h021, 10'h032, 10'h081, 10'h096, 10'h0C1,
         10'h0E1, 10'h101, 10'h121, 10'h1A1, 10'h1C1, 10'h210: extCrLegal = 1'b1;
         default:                                             extCrLegal = 1'b0;
      endcase
   endfunction

   // Float multiply-add form; dbl picks the double group
   function automatic logic extFpALegal(input logic [4:0] xo, input logic dbl);
      unique case (xo)
         5'h12, 5'h14, 5'h15, 5'h16, 5'h19, 5'h1C, 5'h1D, 5'h1E, 5'h1F: extFpALegal = 1'b1;
         5'h17, 5'h1A:                                                extFpALegal = dbl;
         5'h18:                                                       extFpALegal = !dbl;
         default:                                                     extFpALegal = 1'b0;
      endcase
   endfunction

   // Double float group, ten-bit forms
   function automatic logic extFpXLegal(input logic [9:0] xo);
      unique case (xo)
         10'h000, 10'h00C, 10'h00E, 10'h00F, 10'h020, 10'h026, 10'h028, 10'h040,
         10'h046, 10'h048, 10'h086, 10'h088, 10'h108, 10'h247, 10'h2C7: extFpXLegal = 1'b1;
         default:                                                       extFpXLegal = 1'b0;
      endcase
   endfunction

   // Indexed memory forms of the integer group and their size
   function automatic logic [3:0] extMemShape(input logic [9:0] xo);
      // Bit 3 memory, bit 2 float register, bits 1:0 size code
      unique case (xo)
         10'h057, 10'h077, 10'h0D7, 10'h0F7:               extMemShape = 4'h8;
         10'h117, 10'h137, 10'h157, 10'h177, 10'h197,
         10'h1B7, 10'h316, 10'h396:                        extMemShape = 4'h9;
         10'h014, 10'h017, 10'h037, 10'h096, 10'h097, 10'h0B7, 10'h136,
         10'h1B6, 10'h215, 10'h216, 10'h255, 10'h295, 10'h296, 10'h2D5: extMemShape = 4'hA;
         10'h217, 10'h237, 10'h297, 10'h2B7, 10'h3D7:      extMemShape = 4'hE;
         10'h257, 10'h277, 10'h2D7, 10'h2F7:               extMemShape = 4'hF;
         default:                                          extMemShape = 4'h0;
      endcase
   endfunction

   // Supervisor-level encodings of the integer group
   function automatic logic extPriv(input logic [9:0] xo, input logic sprHi);
      unique case (xo)
         10'h053, 10'h092, 10'h0D2, 10'h0F2, 10'h132,
         10'h1D6, 10'h236, 10'h253, 10'h293: extPriv = 1'b1;
         10'h153, 10'h1D3:                   extPriv = sprHi;  // Depends on register number
         default:                            extPriv = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------------------
   // Fetch capture stage
   // ----------------------------------------------------------------------------
   logic        capValid_r;   // Captured word is live
   logic [31:0] capWord_r;    // Captured word
   logic [31:0] capPc_r;      // Captured, aligned address

   // Low address bits are dropped: a word always comes from a word boundary
   wire [31:0] alignedAddr = {fetchAddr[31:`ICD_ALIGN_HI + 1], `ICD_ALIGN_ZERO};  // [RQ1]

   // Capture register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         capValid_r <= 1'b0;
         capWord_r  <= `ICD_WORD_RST;
         capPc_r    <= `ICD_WORD_RST;
      end else begin
         capValid_r <= fetchValid;
         capWord_r  <= fetchWord;    // Whole four-byte word [RQ1]
         capPc_r    <= alignedAddr;
      end
   end

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   icd_dec_if decIf ();
   assign decIf.word = capWord_r;

   icd_prim_dec u_prim (
      .dec (decIf.prim)
   );

   icd_oper_dec u_oper (
      .dec (decIf.oper)
   );

   // ----------------------------------------------------------------------------
   // Classification
   // ----------------------------------------------------------------------------
   // Opcode from the six most significant bits [RQ18]
   wire [5:0] opc     = capWord_r[`ICD_PO_HI:`ICD_PO_LO];
   wire [9:0] xo10    = capWord_r[`ICD_XO_HI:`ICD_XO_LO];
   wire [8:0] xo9     = capWord_r[`ICD_XO9_HI:`ICD_XO_LO];
   wire [4:0] xo5     = capWord_r[`ICD_AXO_HI:`ICD_XO_LO];
   wire       sprHi   = capWord_r[`ICD_SPR_PRIV_BIT];
   wire       allZero = (capWord_r == `ICD_WORD_RST);

   wire isSc  = (opc == `ICD_OPC_SC);
   wire isCr  = (opc == `ICD_OPC_CR);
   wire isInt = (opc == `ICD_OPC_EXT);
   wire isFps = (opc == `ICD_OPC_FPS);
   wire isFpd = (opc == `ICD_OPC_FPD);

   // Assigned extended opcodes per group; anything else there is illegal [RQ10]
   wire intLegal = extIntLegal(xo10) || extXoLegal(xo9);
   wire fpLegal  = extFpALegal(xo5, isFpd) || (isFpd && extFpXLegal(xo10));
   wire extLegal = (isSc && capWord_r[`ICD_SC_BIT]) ||
                   (isCr && extCrLegal(xo10)) ||
                   (isInt && intLegal) ||
                   ((isFps || isFpd) && fpLegal);  // [RQ6] [RQ10]

   // Optional operations left to software emulation
   wire isSqrt   = (isFps || isFpd) && (xo5 == 5'h16);
   wire isFlush  = isInt && (xo10 == 10'h172);
   wire unimpl   = isSqrt || isFlush;  // [RQ15]

   // Class of the captured word
   icd_pkg::icd_class_type cls;
   always_comb begin
      unique case (decIf.pKind)
         icd_pkg::PK_RSV: begin
            // A word of zeros must trap even though its opcode is zero
            cls = allZero ? icd_pkg::CLS_ILLEGAL : icd_pkg::CLS_RESERVED;  // [RQ11] [RQ12]
         end
         icd_pkg::PK_DEF: begin
            cls = icd_pkg::CLS_DEFINED;  // [RQ14]
         end
         icd_pkg::PK_EXT: begin
            cls = extLegal ? icd_pkg::CLS_DEFINED : icd_pkg::CLS_ILLEGAL;  // [RQ7]
         end
         default: begin
            cls = icd_pkg::CLS_ILLEGAL;  // Unassigned and wide-core opcodes [RQ8] [RQ9]
         end
      endcase
   end

   // No reserved encodings are implemented, so reserved words trap as well
   wire trapIll = (cls != icd_pkg::CLS_DEFINED) || unimpl;  // [RQ13] [RQ17] [RQ15]

   // Privilege check uses only opcode fields and the top bit of the special register number, so junk in reserved bits
   // can never slip a supervisor operation past a user program
   wire supOp   = (isCr && (xo10 == 10'h032)) || (isInt && extPriv(xo10, sprHi));
   wire trapPriv = userMode && supOp && !trapIll;  // [RQ16]

   // ----------------------------------------------------------------------------
   // Routing
   // ----------------------------------------------------------------------------
   wire [3:0] xShape = extMemShape(xo10);
   wire       xMem   = isInt && xShape[3];

   // Unit: nothing issues when the word traps [RQ13]
   icd_pkg::icd_unit_type unit;
   always_comb begin
      if (trapIll || trapPriv) begin
         unit = icd_pkg::UNIT_NONE;  // [RQ13] [RQ16]
      end else if (isFps || isFpd) begin
         unit = icd_pkg::UNIT_FPU;  // Single and double precision [RQ4]
      end else if (xMem) begin
         unit = icd_pkg::UNIT_LSU;  // [RQ5]
      end else if (isSc || (isCr && ((xo10 == 10'h032) || (xo10 == 10'h096)))) begin
         unit = icd_pkg::UNIT_SYS;
      end else if (isCr) begin
         unit = icd_pkg::UNIT_BRANCH;
      end else begin
         unit = decIf.pUnit;  // Word-sized integer, D-form memory or primary-opcode branch [RQ4]
      end
   end

   // Memory shape from whichever form the word uses
   wire                    memNxt  = (decIf.pMem || xMem) && (unit == icd_pkg::UNIT_LSU);  // [RQ5]
   wire                    fpNxt   = xMem ? xShape[2] : (decIf.pFp || isFps || isFpd);     // [RQ3]
   icd_pkg::icd_size_type  sizeNxt;
   assign sizeNxt = xMem ? icd_pkg::icd_size_type'(xShape[1:0]) : decIf.pSize;             // [RQ2] [RQ3]

   // ----------------------------------------------------------------------------
   // Issue register
   // ----------------------------------------------------------------------------
   // Class and trap are settled together with the word, before any unit sees it
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         issueValid <= 1'b0;
         issuePc    <= `ICD_WORD_RST;
         issueWord  <= `ICD_WORD_RST;
         issueClass <= icd_pkg::CLS_DEFINED;
         issueUnit  <= icd_pkg::UNIT_NONE;
         memAccess  <= 1'b0;
         memSize    <= icd_pkg::SZ_WORD;
         floatReg   <= 1'b0;
         regDst     <= `ICD_REG_RST;
         regSrcA    <= `ICD_REG_RST;
         regSrcB    <= `ICD_REG_RST;
         progExc    <= 1'b0;
         privExc    <= 1'b0;
         excVector  <= `ICD_WORD_RST;
      end else begin
         issueValid <= capValid_r;                               // [RQ18]
         issuePc    <= capPc_r;
         issueWord  <= capWord_r;
         issueClass <= cls;                                      // [RQ6]
         issueUnit  <= capValid_r ? unit : icd_pkg::UNIT_NONE;
         memAccess  <= capValid_r && memNxt;
         memSize    <= sizeNxt;
         floatReg   <= fpNxt;
         regDst     <= decIf.rDst;
         regSrcA    <= decIf.rSrcA;
         regSrcB    <= decIf.rSrcB;
         progExc    <= capValid_r && (trapIll || trapPriv);    // [RQ13]
         privExc    <= capValid_r && trapPriv;                   // [RQ16]
         excVector  <= (capValid_r && (trapIll || trapPriv)) ? `ICD_PROG_VEC : `ICD_WORD_RST;  // [RQ13]
      end
   end

endmodule // icd_instruction_class_decoder

// >>> icd_oper_dec.sv
// Operand register index extraction for the 32-entry register sets
`timescale 1ns/10ps
`include "icd_regs.svh"
module icd_oper_dec (
   icd_dec_if.oper dec
);

   // ----------------------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------------------
   // Five bits address all 32 entries of integer_register_set or float_register_set
   assign dec.rDst  = dec.word[`ICD_RT_HI:`ICD_RT_LO];  // [RQ2] [RQ3]
   assign dec.rSrcA = dec.word[`ICD_RA_HI:`ICD_RA_LO];
   assign dec.rSrcB = dec.word[`ICD_RB_HI:`ICD_RB_LO];

endmodule // icd_oper_dec

// >>> icd_pkg.sv
// Shared types for the instruction class decoder
package icd_pkg;

   // Architectural class of a word
   typedef enum logic [1:0] {
      CLS_DEFINED  = 2'b00,
      CLS_RESERVED = 2'b01,
      CLS_ILLEGAL  = 2'b10
   } icd_class_type;

   // What the primary opcode alone tells us
   typedef enum logic [2:0] {
      PK_RSV   = 3'b000,  // Opcode zero
      PK_ILL   = 3'b001,  // Never assigned
      PK_ILL64 = 3'b010,  // Wide-core only
      PK_DEF   = 3'b011,  // Complete without extended opcode
      PK_EXT   = 3'b100   // Extended opcode decides
   } icd_pkind_type;

   // Execution unit that receives the instruction
   typedef enum logic [2:0] {
      UNIT_NONE   = 3'b000,
      UNIT_INT    = 3'b001,
      UNIT_FPU    = 3'b010,
      UNIT_LSU    = 3'b011,
      UNIT_BRANCH = 3'b100,
      UNIT_SYS    = 3'b101
   } icd_unit_type;

   // Memory operand size
   typedef enum logic [1:0] {
      SZ_BYTE   = 2'b00,
      SZ_HALF   = 2'b01,
      SZ_WORD   = 2'b10,
      SZ_DOUBLE = 2'b11
   } icd_size_type;

endpackage

// >>> icd_prim_dec.sv
// Primary opcode sorter: class hint, unit and load/store shape
`timescale 1ns/10ps
`include "icd_regs.svh"
module icd_prim_dec (
   icd_dec_if.prim dec
);

   // ----------------------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------------------
   wire [5:0] opc = dec.word[`ICD_PO_HI:`ICD_PO_LO];  // Primary opcode
   wire       isMem = (opc >= 6'h20) && (opc <= 6'h37);  // D-form load/store block
   wire       isFpMem = (opc >= 6'h30);                  // Upper part moves float registers

   // Verdict on the primary opcode alone
   always_comb begin
      unique case (opc)
         6'h00:                                     dec.pKind = icd_pkg::PK_RSV;
         6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
         6'h38, 6'h39, 6'h3C, 6'h3D:                dec.pKind = icd_pkg::PK_ILL;    // [RQ8]
         6'h02, 6'h1E, 6'h3A, 6'h3E:                dec.pKind = icd_pkg::PK_ILL64;  // [RQ9]
         6'h11, 6'h13, 6'h1F, 6'h3B, 6'h3F:         dec.pKind = icd_pkg::PK_EXT;    // [RQ6]
         default:                                   dec.pKind = icd_pkg::PK_DEF;
      endcase
   end

   // Unit for forms that need no extended opcode
   always_comb begin
      if (isMem) begin
         dec.pUnit = icd_pkg::UNIT_LSU;  // Memory only through loads and stores [RQ5]
      end else if ((opc == 6'h10) || (opc == 6'h12)) begin
         dec.pUnit = icd_pkg::UNIT_BRANCH;
      end else begin
         dec.pUnit = icd_pkg::UNIT_INT;  // Word-sized integer work [RQ4]
      end
   end

   // Load/store shape: integer byte, half, word; float word or double
   assign dec.pMem = isMem;
   assign dec.pFp  = isMem && isFpMem;  // [RQ3]
   always_comb begin
      if (isFpMem) begin
         dec.pSize = opc[1] ? icd_pkg::SZ_DOUBLE : icd_pkg::SZ_WORD;  // [RQ3]
      end else if (opc >= 6'h28) begin
         dec.pSize = (opc >= 6'h2E) ? icd_pkg::SZ_WORD : icd_pkg::SZ_HALF;  // [RQ2]
      end else begin
         dec.pSize = opc[1] ? icd_pkg::SZ_BYTE : icd_pkg::SZ_WORD;  // [RQ2]
      end
   end

endmodule // icd_prim_dec

// >>> icd_regs.svh
// Field positions, opcode encodings and reset values for the instruction class decoder
`ifndef ICD_REGS_SVH
`define ICD_REGS_SVH

// ----------------------------------------------------------------------------
// Instruction word fields (bit 31 is the most significant bit)
// ----------------------------------------------------------------------------
`define ICD_PO_HI        31      // Primary opcode, top six bits
`define ICD_PO_LO        26
`define ICD_RT_HI        25      // Target / source register index
`define ICD_RT_LO        21
`define ICD_RA_HI        20      // First source register index
`define ICD_RA_LO        16
`define ICD_RB_HI        15      // Second source register index
`define ICD_RB_LO        11
`define ICD_XO_HI        10      // Ten-bit extended opcode
`define ICD_XO_LO        1
`define ICD_XO9_HI       9       // Nine-bit extended opcode, overflow-enable form
`define ICD_OE_BIT       10      // Overflow-enable bit of that form
`define ICD_AXO_HI       5       // Five-bit extended opcode, float multiply-add form
`define ICD_SC_BIT       1       // Must be set in the system call form
`define ICD_SPR_PRIV_BIT 15      // Top bit of the special register number
`define ICD_ALIGN_HI     1       // Byte offset inside a word
`define ICD_ALIGN_LO     0

// ----------------------------------------------------------------------------
// Primary opcodes steered by the core
// ----------------------------------------------------------------------------
`define ICD_OPC_RSV      6'h00   // Reserved space
`define ICD_OPC_SC       6'h11   // System call
`define ICD_OPC_CR       6'h13   // Condition and branch-to-register group
`define ICD_OPC_EXT      6'h1F   // Integer extended group
`define ICD_OPC_FPS      6'h3B   // Single-precision float group
`define ICD_OPC_FPD      6'h3F   // Double-precision float group

// ----------------------------------------------------------------------------
// Vectors and reset values
// ----------------------------------------------------------------------------
`define ICD_PROG_VEC     32'h0000_0700  // Program exception vector offset
`define ICD_WORD_RST     32'h0000_0000
`define ICD_ALIGN_ZERO   2'h0
`define ICD_REG_RST      5'h00

`endif

// >>> tb_top.sv
// Self-checking bench for the instruction class decoder
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   logic                   sys_clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   userMode = 1'b0;
   logic                   fetchValid, issueValid, memAccess, floatReg, progExc, privExc;
   logic [31:0]            fetchAddr, fetchWord, issuePc, issueWord, excVector, mw, ma;
   logic [31:0]            lfsr_r = 32'h6CB5BE54;
   logic [4:0]             regDst, regSrcA, regSrcB;
   icd_pkg::icd_class_type issueClass;
   icd_pkg::icd_unit_type  issueUnit;
   icd_pkg::icd_size_type  memSize;
   int                     mismatches = 0;
   int                     nCompared = 0;
   int                     kc;
   logic [31:0]            qWord[$], qAddr[$];
   logic [5:0]             illOps[14] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16,
                                         6'h1E, 6'h38, 6'h39, 6'h3A, 6'h3C, 6'h3D, 6'h3E};
   always #10 sys_clk = ~sys_clk;
   icd_fetch_model FM (.sys_clk(sys_clk), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchWord(fetchWord));
   icd_instruction_class_decoder DUT (.sys_clk(sys_clk), .rst(rst), .fetchValid(fetchValid),
      .fetchAddr(fetchAddr), .fetchWord(fetchWord), .userMode(userMode), .issueValid(issueValid),
      .issuePc(issuePc), .issueWord(issueWord), .issueClass(issueClass), .issueUnit(issueUnit),
      .memAccess(memAccess), .memSize(memSize), .floatReg(floatReg), .regDst(regDst), .regSrcA(regSrcA),
      .regSrcB(regSrcB), .progExc(progExc), .privExc(privExc), .excVector(excVector));
   function automatic logic [31:0] nextRand(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Model: 0 defined, 1 reserved, 2 illegal, 4 trapped defined, -1 unknown
   function automatic int expClass(logic [31:0] w);
      if (w[31:26] == 6'h00) return (w == 32'h0) ? 2 : 1;
      if (w[31:26] inside {illOps}) return 2;
      if ((w[31:26] == 6'h3B || w[31:26] == 6'h3F) && w[5:1] == 5'h16) return 4;
      if (w == 32'h7C0002E4) return 4;
      if (w[31:26] == 6'h1F && w[10:1] == 10'h10A) return 0;
      return -1;
   endfunction
   task automatic send(input logic [31:0] w);
      lfsr_r = nextRand(lfsr_r);
      qWord.push_back(w);
      qAddr.push_back(lfsr_r);
      FM.offer(w, lfsr_r);
      userMode = lfsr_r[7];
   endtask
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Each issued word matches the oldest one offered
   always @(negedge sys_clk) begin
      if (!rst && issueValid === 1'b1 && qWord.size() > 0) begin
         mw = qWord.pop_front();
         ma = qAddr.pop_front();
         kc = expClass(mw);
         `CHK(issueWord, mw)
         `CHK(issuePc, ma & 32'hFFFF_FFFC)
         `CHK(({regDst, regSrcA, regSrcB}), mw[25:11])
         if (kc >= 0) begin
            `CHK(issueClass, 2'(kc % 4))
            `CHK(({progExc, privExc}), ({1'(kc != 0), 1'b0}))
            `CHK(issueUnit, kc ? icd_pkg::UNIT_NONE : icd_pkg::UNIT_INT)
            `CHK(excVector, (kc != 0) ? 32'h0000_0700 : 32'h0000_0000)
         end
         if (kc == 0) `CHK(({memAccess, floatReg}), 2'b00)
         if (mw[31:26] == 6'h20) `CHK(memSize, icd_pkg::SZ_WORD)
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      send(32'h0000_0000);
      send(32'h0000_0001);
      foreach (illOps[i]) send({illOps[i], lfsr_r[25:0]});
      send({6'h3F, lfsr_r[25:6], 5'h16, lfsr_r[0]});
      send({6'h3B, lfsr_r[25:6], 5'h16, lfsr_r[0]});
      send(32'h7C0002E4);
      send({6'h20, lfsr_r[25:0]});
      // Random gaps, adds and raw words
      for (int i = 0; i < 300; i++) begin
         lfsr_r = nextRand(lfsr_r);
         if (lfsr_r[3]) FM.idle();
         else if (lfsr_r[4]) send({6'h1F, lfsr_r[25:11], 10'h10A, lfsr_r[0]});
         else send(lfsr_r);
      end
      repeat (3) FM.idle();
      `CHK(qWord.size(), 0)
      wrap_up();
   end
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
endmodule // tb_top
